/* File: dz_pkg.sv */
package dz_pkg;
    // clock and timing
    localparam int unsigned CLK_PERIOD_NS  = 50;
    localparam int unsigned FILT_PERIOD_NS = 166000;
    localparam int unsigned FILT_CYC       = (FILT_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned MS_NS          = 1000000;
    localparam int unsigned MS_CYC         = MS_NS / CLK_PERIOD_NS;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_RANGE1 = 8'h04;
    localparam logic [7:0] OFS_RANGE2 = 8'h08;
    localparam logic [7:0] OFS_HOLD   = 8'h0C;
    localparam logic [7:0] OFS_EXCESS = 8'h10;
    localparam logic [7:0] OFS_GEAR   = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    localparam logic [7:0] OFS_DEV    = 8'h1C;

    // control field positions
    localparam int unsigned CTRL_MODE_LSB = 0;
    localparam int unsigned CTRL_COND_LSB = 4;
    localparam int unsigned CTRL_UNIT_BIT = 8;

    // setting limits
    localparam logic [2:0]  MODE_MAX  = 3'h4;
    localparam logic [18:0] RANGE_MAX = 19'h40000;
    localparam logic [14:0] HOLD_MAX  = 15'h7530;

    // reset values
    localparam logic [2:0]  RST_MODE   = 3'h0;
    localparam logic [1:0]  RST_COND   = 2'h0;
    localparam logic [18:0] RST_RANGE1 = 19'h0000A;
    localparam logic [18:0] RST_RANGE2 = 19'h0000A;
    localparam logic [14:0] RST_HOLD   = 15'h0000;
    localparam logic [18:0] RST_EXCESS = 19'h186A0;
    localparam logic [15:0] RST_GEAR   = 16'h0001;

    // zeroing modes
    localparam logic [2:0] MODE_OFF   = 3'h0;
    localparam logic [2:0] MODE_LVL   = 3'h1;
    localparam logic [2:0] MODE_LVL_F = 3'h2;
    localparam logic [2:0] MODE_EDG   = 3'h3;
    localparam logic [2:0] MODE_EDG_F = 3'h4;

    typedef enum logic [1:0] {
        HS_IDLE  = 2'b00,
        HS_HOLD  = 2'b01,
        HS_SPENT = 2'b11
    } dz_hold_t;

    typedef struct packed {
        logic [2:0]         mode;
        logic [1:0]         cond;
        logic               unit;
        logic [18:0]        rng1;
        logic [18:0]        rng2;
        logic [14:0]        hold;
        logic [18:0]        elim;
        logic [15:0]        gear;
        logic               sync1;
        logic               sync2;
        logic               prev;
        logic signed [27:0] dev;
        logic               clr;
        logic               primary_in_position_output;
        logic               second_in_position_output;
        logic               excess;
        dz_hold_t           hst;
        logic [14:0]        hcnt;
        logic [14:0]        mscnt;
        logic               wr_pend;
        logic [5:0]         waddr;
        logic [31:0]        rdata;
        logic               ready;
    } dz_state_t;
endpackage

/* File: dz_sample_filter.sv */
`timescale 1ns/10ps
module dz_sample_filter #(
    parameter int unsigned PERIOD = dz_pkg::FILT_CYC
) (
    input  wire logic ref_clk_i,
    input  wire logic rst_n_i,
    input  wire logic raw_i,
    output logic      level_o
);
    typedef struct packed {
        logic [11:0] cnt;
        logic        last;
        logic        level;
    } dz_filt_t;

    dz_filt_t q;
    dz_filt_t d;

    // sample once a period, take the level only when two samples agree
    always_comb begin
        d = q;
        if (q.cnt == 12'(PERIOD - 1)) begin
            d.cnt  = 12'h000;
            d.last = raw_i;
            if (raw_i == q.last) begin
                d.level = raw_i;
            end
        end else begin
            d.cnt = q.cnt + 12'h001;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign level_o = q.level;

    property p_filt_agree;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (q.level != $past(q.level)) |-> (q.level == q.last && $past(q.last) == q.level);
    endproperty
    a_filt_agree: assert property (p_filt_agree) else $error("filter took an unconfirmed level");
endmodule

/* File: dz_top.sv */
// Our own choices: the AHB-Lite register port and the register addresses.
`timescale 1ns/10ps
// Functional notes
// - zeroing mode 0 to 4; mode 0 never clears the deviation counter.
// - modes 1 and 2 hold the counter at zero while the input is on.
// - modes 3 and 4 clear once on the off-to-on edge only.
// - modes 2 and 4 use the filtered input, modes 1 and 3 the raw one.
// - input is on while its optocoupler conducts (pin high).
// - absolute deviation is compared with the range to drive the primary output.
// - range accepts 0 to 262144, default unit is command units.
// - encoder unit select makes range and excess limit encoder units.
// - condition 0 to 3; condition 0 asserts whenever deviation is within range.
// - condition 1 also needs no position command.
// - condition 2 also needs no command and zero speed.
// - condition 3 holds output for the hold time, then follows status.
// - hold time 0 to 30000 ms; 0 holds until next command.
// - a command during a nonzero hold drops the output at once.
// - second output follows only its own range, 0 to 262144.
// - command presence comes from the filtered command stream.
module dz_top #(
    parameter int unsigned MS_CYCLES = dz_pkg::MS_CYC
) (
    input  wire logic        ref_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        zero_pin_i,
    input  wire logic        cmd_present_i,
    input  wire logic        zero_speed_i,
    input  wire logic        cmd_inc_i,
    input  wire logic        cmd_dec_i,
    input  wire logic        fb_inc_i,
    input  wire logic        fb_dec_i,
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic             hreadyout_o,
    output logic             hresp_o,
    output logic [31:0]      hrdata_o,
    output logic             dev_clear_o,
    output logic             in_pos1_o,
    output logic             in_pos2_o,
    output logic             dev_excess_o
);
    dz_pkg::dz_state_t q;
    dz_pkg::dz_state_t d;
    logic              filt_lvl;
    logic              sel_in;
    logic              clr;
    logic signed [27:0] step;
    logic [27:0]       absdev;
    logic              within1;
    logic              within2;
    logic              over;
    logic              hold_tick;

    // filtered copy of the zeroing input, fed from the synchronised pin
    dz_sample_filter #(
        .PERIOD (dz_pkg::FILT_CYC)
    ) u_filt (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .raw_i     (q.sync2),
        .level_o   (filt_lvl)
    );

    // thresholds scale by the gear ratio unless encoder units are chosen
    function automatic logic [34:0] scaled(input logic [18:0] r, input logic [15:0] g,
                                           input logic enc);
        logic [15:0] f;
        f = enc ? 16'h0001 : g;
        scaled = {16'h0000, r} * {19'h00000, f};
    endfunction

    function automatic logic [18:0] clamp_rng(input logic [31:0] v);
        clamp_rng = (v > {13'h0000, dz_pkg::RANGE_MAX}) ? dz_pkg::RANGE_MAX : v[18:0];
    endfunction

    // read mux over the next state, so a read just after a write sees the new value
    function automatic logic [31:0] rd_mux(input dz_pkg::dz_state_t s, input logic [7:0] a);
        logic [31:0] r;
        r = 32'h0000_0000;
        unique case (a)
            dz_pkg::OFS_CTRL: begin
                r[dz_pkg::CTRL_MODE_LSB +: 3] = s.mode;
                r[dz_pkg::CTRL_COND_LSB +: 2] = s.cond;
                r[dz_pkg::CTRL_UNIT_BIT]      = s.unit;
            end
            dz_pkg::OFS_RANGE1: r = {13'h0000, s.rng1};
            dz_pkg::OFS_RANGE2: r = {13'h0000, s.rng2};
            dz_pkg::OFS_HOLD:   r = {17'h00000, s.hold};
            dz_pkg::OFS_EXCESS: r = {13'h0000, s.elim};
            dz_pkg::OFS_GEAR:   r = {16'h0000, s.gear};
            dz_pkg::OFS_STATUS: r = {26'h0000000, s.prev, s.clr, s.excess, s.second_in_position_output, s.primary_in_position_output,
                                     s.hst == dz_pkg::HS_HOLD};
            dz_pkg::OFS_DEV:    r = {{4{s.dev[27]}}, s.dev};
            default:            r = 32'h0000_0000; // unmapped reads as zero
        endcase
        return r;
    endfunction

    // comparison path from present state; step taken straight from the pulse inputs
    always_comb begin
        step    = 28'(cmd_inc_i) - 28'(cmd_dec_i) - 28'(fb_inc_i) + 28'(fb_dec_i);
        absdev  = q.dev[27] ? 28'(-q.dev) : 28'(q.dev);
        within1 = {7'h00, absdev} <= scaled(q.rng1, q.gear, q.unit);
        within2 = {7'h00, absdev} <= scaled(q.rng2, q.gear, q.unit);
        over    = {7'h00, absdev} >  scaled(q.elim, q.gear, q.unit);
        hold_tick = (q.mscnt == 15'(MS_CYCLES - 1));
        // pin high means the optocoupler conducts
        sel_in  = (q.mode == dz_pkg::MODE_LVL_F || q.mode == dz_pkg::MODE_EDG_F)
                  ? filt_lvl : q.sync2;
        unique case (q.mode)
            dz_pkg::MODE_LVL, dz_pkg::MODE_LVL_F: clr = sel_in;
            dz_pkg::MODE_EDG, dz_pkg::MODE_EDG_F: clr = sel_in & ~q.prev;
            default:                              clr = 1'b0;
        endcase
    end

    // whole next state: bus, synchroniser, counter, hold machine, outputs
    always_comb begin
        d = q;
        d.ready = 1'b1;
        d.sync1 = zero_pin_i;
        d.sync2 = q.sync1;
        d.prev  = sel_in;
        d.clr   = clr;
        d.dev   = clr ? 28'sh0000000 : q.dev + step;

        // data phase of a write lands here, one cycle after its address phase
        if (q.wr_pend) begin
            unique case ({q.waddr, 2'b00})
                dz_pkg::OFS_CTRL: begin
                    d.mode = (hwdata_i[dz_pkg::CTRL_MODE_LSB +: 3] > dz_pkg::MODE_MAX)
                             ? dz_pkg::MODE_MAX : hwdata_i[dz_pkg::CTRL_MODE_LSB +: 3];
                    d.cond = hwdata_i[dz_pkg::CTRL_COND_LSB +: 2];
                    d.unit = hwdata_i[dz_pkg::CTRL_UNIT_BIT];
                end
                dz_pkg::OFS_RANGE1: d.rng1 = clamp_rng(hwdata_i);
                dz_pkg::OFS_RANGE2: d.rng2 = clamp_rng(hwdata_i);
                dz_pkg::OFS_HOLD: begin
                    d.hold = (hwdata_i > {17'h00000, dz_pkg::HOLD_MAX})
                             ? dz_pkg::HOLD_MAX : hwdata_i[14:0];
                end
                dz_pkg::OFS_EXCESS: d.elim = clamp_rng(hwdata_i);
                dz_pkg::OFS_GEAR:   d.gear = hwdata_i[15:0];
                default: ;
            endcase
        end

        // address phase; only whole-word transfers are expected, hsize is not checked
        d.wr_pend = 1'b0;
        if (hsel_i && htrans_i[1] && hready_i) begin
            d.wr_pend = hwrite_i;
            d.waddr   = haddr_i[7:2];
            if (!hwrite_i) begin
                d.rdata = rd_mux(d, {haddr_i[7:2], 2'b00});
            end
        end

        // hold machine only runs under condition 3
        d.mscnt = hold_tick ? 15'h0000 : q.mscnt + 15'h0001;
        if (q.cond != 2'h3) begin
            d.hst  = dz_pkg::HS_IDLE;
            d.hcnt = 15'h0000;
        end else begin
            unique case (q.hst)
                dz_pkg::HS_IDLE: begin
                    if (!cmd_present_i && within1) begin
                        d.hst   = dz_pkg::HS_HOLD;
                        d.hcnt  = 15'h0000;
                        d.mscnt = 15'h0000; // restart the ms tick so the hold is whole ms
                    end
                end
                dz_pkg::HS_HOLD: begin
                    if (cmd_present_i) begin
                        d.hst = dz_pkg::HS_IDLE;
                    end else if (q.hold != 15'h0000 && hold_tick) begin
                        d.hcnt = q.hcnt + 15'h0001;
                        if (q.hcnt + 15'h0001 >= q.hold) begin
                            d.hst = dz_pkg::HS_SPENT;
                        end
                    end
                end
                dz_pkg::HS_SPENT: begin
                    if (cmd_present_i) begin
                        d.hst = dz_pkg::HS_IDLE;
                    end
                end
                default: d.hst = dz_pkg::HS_IDLE;
            endcase
        end

        // primary output by condition; zero hold time leaves the hold state only on a command
        unique case (q.cond)
            2'h0: d.primary_in_position_output = within1;
            2'h1: d.primary_in_position_output = !cmd_present_i && within1;
            2'h2: d.primary_in_position_output = !cmd_present_i && zero_speed_i && within1;
            default: d.primary_in_position_output = (d.hst == dz_pkg::HS_HOLD)
                              || (d.hst == dz_pkg::HS_SPENT && !cmd_present_i && within1);
        endcase
        d.second_in_position_output   = within2;
        d.excess = over;
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q       <= '0;
            q.mode  <= dz_pkg::RST_MODE;
            q.cond  <= dz_pkg::RST_COND;
            q.rng1  <= dz_pkg::RST_RANGE1;
            q.rng2  <= dz_pkg::RST_RANGE2;
            q.hold  <= dz_pkg::RST_HOLD;
            q.elim  <= dz_pkg::RST_EXCESS;
            q.gear  <= dz_pkg::RST_GEAR;
            q.hst   <= dz_pkg::HS_IDLE;
            q.ready <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign hreadyout_o  = q.ready;
    assign hresp_o      = 1'b0;
    assign hrdata_o     = q.rdata;
    assign dev_clear_o  = q.clr;
    assign in_pos1_o    = q.primary_in_position_output;
    assign in_pos2_o    = q.second_in_position_output;
    assign dev_excess_o = q.excess;

    property p_mode0;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (q.mode == dz_pkg::MODE_OFF) |=> !dev_clear_o;
    endproperty
    a_mode0: assert property (p_mode0) else $error("clear in mode 0");

    property p_level;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (q.mode == dz_pkg::MODE_LVL && q.sync2) |=> (dev_clear_o && q.dev == 28'sh0000000);
    endproperty
    a_level: assert property (p_level) else $error("level clear missing");

    property p_edge_once;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (q.mode == dz_pkg::MODE_EDG && q.sync2 && q.prev) |=> !dev_clear_o;
    endproperty
    a_edge_once: assert property (p_edge_once) else $error("edge clear repeated");

    property p_filt_sel;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (q.mode == dz_pkg::MODE_LVL_F) |=> (dev_clear_o == $past(filt_lvl));
    endproperty
    a_filt_sel: assert property (p_filt_sel) else $error("filtered input not used");

    property p_cond1;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (q.cond == 2'h1 && cmd_present_i) |=> !in_pos1_o;
    endproperty
    a_cond1: assert property (p_cond1) else $error("in position during command");

    property p_cond2;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (q.cond == 2'h2 && !zero_speed_i) |=> !in_pos1_o;
    endproperty
    a_cond2: assert property (p_cond2) else $error("in position without zero speed");

    property p_hold_drop;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (q.cond == 2'h3 && q.hst == dz_pkg::HS_HOLD && cmd_present_i) |=> !in_pos1_o;
    endproperty
    a_hold_drop: assert property (p_hold_drop) else $error("hold not dropped");

    property p_hold_inf;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (q.cond == 2'h3 && q.hold == 15'h0000 && q.hst == dz_pkg::HS_HOLD && !cmd_present_i)
        |=> in_pos1_o;
    endproperty
    a_hold_inf: assert property (p_hold_inf) else $error("infinite hold lost");

    property p_second_in_position_output;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        1'b1 |=> (in_pos2_o == $past(within2));
    endproperty
    a_second_in_position_output: assert property (p_second_in_position_output) else $error("second output wrong");

    property p_range;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (q.rng1 <= dz_pkg::RANGE_MAX) && (q.rng2 <= dz_pkg::RANGE_MAX);
    endproperty
    a_range: assert property (p_range) else $error("range above maximum");

    // raw edge must clear in the very next cycle, counter included
    property p_edge_raw;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (q.mode == dz_pkg::MODE_EDG && q.sync2 && !q.prev) |=> (dev_clear_o && q.dev == 28'sh0000000);
    endproperty
    a_edge_raw: assert property (p_edge_raw) else $error("edge clear missing");

    property p_edge_filt;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (q.mode == dz_pkg::MODE_EDG_F && filt_lvl && !q.prev) |=> dev_clear_o;
    endproperty
    a_edge_filt: assert property (p_edge_filt) else $error("filtered edge clear missing");

    property p_raw_sel;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (q.mode == dz_pkg::MODE_LVL) |=> (dev_clear_o == $past(q.sync2));
    endproperty
    a_raw_sel: assert property (p_raw_sel) else $error("raw input polarity wrong");

    property p_clr_zero;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        dev_clear_o |-> (q.dev == 28'sh0000000);
    endproperty
    a_clr_zero: assert property (p_clr_zero) else $error("counter not zero on clear");

    property p_cond0;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (q.cond == 2'h0) |=> (in_pos1_o == $past(within1));
    endproperty
    a_cond0: assert property (p_cond0) else $error("condition 0 output wrong");

    property p_hold_enter;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (q.cond == 2'h3 && q.hst == dz_pkg::HS_IDLE && !cmd_present_i && within1) |=> in_pos1_o;
    endproperty
    a_hold_enter: assert property (p_hold_enter) else $error("hold not entered");

    // once the hold is spent the output follows command and range again
    property p_spent_follow;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (q.cond == 2'h3 && q.hst == dz_pkg::HS_SPENT && (cmd_present_i || !within1))
        |=> !in_pos1_o;
    endproperty
    a_spent_follow: assert property (p_spent_follow) else $error("spent hold kept output");

    c_level: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        q.mode == dz_pkg::MODE_LVL_F && dev_clear_o);
    c_edge: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        q.mode == dz_pkg::MODE_EDG && dev_clear_o);
    c_spent: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        q.hst == dz_pkg::HS_SPENT && in_pos1_o);
    c_hold0: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        q.cond == 2'h3 && q.hold == 15'h0000 && in_pos1_o);
endmodule

/* File: dz_host_model.sv */
`timescale 1ns/10ps
// stands in for the host position controller: zeroing pin, command and
// zero-speed levels, and the encoder-unit pulse streams of both directions
module dz_host_model (
    input  wire logic ref_clk_i,
    output logic      zero_pin_o,
    output logic      cmd_present_o,
    output logic      zero_speed_o,
    output logic      cmd_inc_o,
    output logic      cmd_dec_o,
    output logic      fb_inc_o,
    output logic      fb_dec_o
);
    logic [3:0] pls;

    // pulse lines fan out to their own ports
    assign cmd_inc_o = pls[0];
    assign cmd_dec_o = pls[1];
    assign fb_inc_o  = pls[2];
    assign fb_dec_o  = pls[3];

    // everything idle, pin off, before the first edge
    initial begin
        zero_pin_o    = 1'b0;
        cmd_present_o = 1'b0;
        zero_speed_o  = 1'b0;
        pls           = 4'h0;
    end

    // a low cycle after each pulse keeps every pulse one clean cycle wide
    task automatic step(input int kind, input int n);
        repeat (n) begin
            @(posedge ref_clk_i);
            pls[kind] <= 1'b1;
            @(posedge ref_clk_i);
            pls[kind] <= 1'b0;
        end
    endtask

    // pin high means the optocoupler conducts; cmd is the post-filter command level
    task automatic levels(input logic p, input logic c, input logic z);
        @(posedge ref_clk_i);
        zero_pin_o    <= p;
        cmd_present_o <= c;
        zero_speed_o  <= z;
    endtask
endmodule

/* File: dz_top_bench.sv */
`timescale 1ns/10ps
module dz_top_bench;
    logic        ref_clk, rst_n, hsel, hwrite, hreadyout, hresp;
    logic        dev_clear, in_pos1, in_pos2, dev_excess, e;
    logic        zpin, cmdp, zspd, ci, cd, fi, fd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata, r;
    logic [27:0] dev_exp;
    int          err_total, n_checks;
    int          wid [5] = '{100, 10000, 20000, 2000, 20000};

    dz_top #(.MS_CYCLES(20)) dut_u (
        .ref_clk_i(ref_clk), .rst_n_i(rst_n), .zero_pin_i(zpin), .cmd_present_i(cmdp),
        .zero_speed_i(zspd), .cmd_inc_i(ci), .cmd_dec_i(cd), .fb_inc_i(fi), .fb_dec_i(fd),
        .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
        .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hreadyout), .hreadyout_o(hreadyout),
        .hresp_o(hresp), .hrdata_o(hrdata), .dev_clear_o(dev_clear), .in_pos1_o(in_pos1),
        .in_pos2_o(in_pos2), .dev_excess_o(dev_excess)
    );

    dz_host_model host_u (
        .ref_clk_i(ref_clk), .zero_pin_o(zpin), .cmd_present_o(cmdp), .zero_speed_o(zspd),
        .cmd_inc_o(ci), .cmd_dec_o(cd), .fb_inc_o(fi), .fb_dec_o(fd)
    );

    // 20 MHz
    always #25 ref_clk = ~ref_clk;

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
            err_total++;
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    // waits for hready with a bound, so a stuck slave ends the run
    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) begin
            err_total++;
            print_verdict();
        end
    endtask

    // one single word transfer: address phase, then data phase
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {24'h0, a};
        hwrite <= w;
        wait_rdy();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy();
        r = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        ahb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        ahb(1'b0, a, 32'h0);
        chk(r, exp);
        chk({31'h0, hresp}, 32'h0);
    endtask

    task automatic ip(input logic e1, input logic e2);
        cyc(3);
        chk({31'h0, in_pos1}, {31'h0, e1});
        chk({31'h0, in_pos2}, {31'h0, e2});
    endtask

    initial begin
        ref_clk = 1'b0;
        rst_n = 1'b0;
        hsel = 1'b0;
        hwrite = 1'b0;
        htrans = 2'h0;
        hsize = 3'h2;
        haddr = 32'h0;
        hwdata = 32'h0;
        err_total = 0;
        n_checks = 0;
        dev_exp = 28'h0;
        cyc(20);
        rst_n <= 1'b1;
        cyc(2);
        // reset values, unmapped place, clamping of oversized settings
        rd(dz_pkg::OFS_CTRL, 32'h0);
        rd(dz_pkg::OFS_RANGE1, 32'h0000000A);
        rd(dz_pkg::OFS_HOLD, 32'h0);
        rd(dz_pkg::OFS_EXCESS, 32'h000186A0);
        wr(8'h20, 32'h0000FFFF);
        rd(8'h20, 32'h0);
        wr(dz_pkg::OFS_RANGE2, 32'h0007FFFF);
        rd(dz_pkg::OFS_RANGE2, 32'h00040000);
        wr(dz_pkg::OFS_HOLD, 32'h0000FFFF);
        rd(dz_pkg::OFS_HOLD, 32'h00007530);
        wr(dz_pkg::OFS_RANGE2, 32'h0000000A);
        // absolute deviation against both ranges, each output on its own range
        ip(1'b1, 1'b1);
        host_u.step(0, 11);
        ip(1'b0, 1'b0);
        wr(dz_pkg::OFS_RANGE2, 32'h00000014);
        ip(1'b0, 1'b1);
        host_u.step(2, 22);
        ip(1'b0, 1'b1);
        host_u.step(3, 11);
        ip(1'b1, 1'b1);
        // each zeroing mode: pin held its minimum width, then more pulses while still on
        for (int m = 0; m < 5; m++) begin
            wr(dz_pkg::OFS_CTRL, 32'(m));
            host_u.step(0, 5);
            dev_exp = dev_exp + 28'h5;
            // a pulse too short for the filter must leave a nonzero count alone
            if (m == 2 || m == 4) begin
                host_u.levels(1'b1, 1'b0, 1'b0);
                cyc(20);
                host_u.levels(1'b0, 1'b0, 1'b0);
                cyc(20);
                rd(dz_pkg::OFS_DEV, {4'h0, dev_exp});
            end
            host_u.levels(1'b1, 1'b0, 1'b0);
            cyc(wid[m]);
            host_u.step(0, 3);
            dev_exp = (m == 0) ? dev_exp + 28'h3 : (m < 3) ? 28'h0 : 28'h3;
            cyc(2);
            chk({31'h0, dev_clear}, {31'h0, (m == 1 || m == 2)});
            rd(dz_pkg::OFS_DEV, {4'h0, dev_exp});
            host_u.levels(1'b0, 1'b0, 1'b0);
            // after a long pin the filter needs about two periods to fall back
            cyc((m == 1 || m == 2) ? 11000 : 20);
        end
        // conditions 0 to 2 over every command / zero-speed combination
        for (int c = 0; c < 3; c++) begin
            wr(dz_pkg::OFS_CTRL, 32'(c) << 4);
            for (int k = 0; k < 4; k++) begin
                host_u.levels(1'b0, k[0], k[1]);
                e = (c == 0) ? 1'b1 : (c == 1) ? !k[0] : (!k[0] && k[1]);
                ip(e, 1'b1);
            end
        end
        // command units scale by the gear; encoder units use the raw setting
        wr(dz_pkg::OFS_CTRL, 32'h0);
        host_u.levels(1'b0, 1'b0, 1'b0);
        host_u.step(0, 10);
        ip(1'b0, 1'b1);
        wr(dz_pkg::OFS_GEAR, 32'h4);
        ip(1'b1, 1'b1);
        wr(dz_pkg::OFS_EXCESS, 32'hC);
        cyc(2);
        chk({31'h0, dev_excess}, 32'h0);
        wr(dz_pkg::OFS_CTRL, 32'h100);
        ip(1'b0, 1'b1);
        chk({31'h0, dev_excess}, 32'h1);
        // condition 3 in encoder units, so ten feedback pulses bring the count back into range
        wr(dz_pkg::OFS_CTRL, 32'h130);
        host_u.step(2, 10);
        // timed hold of 2 ms (40 cycles here) survives leaving the range
        wr(dz_pkg::OFS_HOLD, 32'h2);
        host_u.levels(1'b0, 1'b1, 1'b0);
        ip(1'b0, 1'b1);
        host_u.levels(1'b0, 1'b0, 1'b0);
        host_u.step(0, 10);
        ip(1'b1, 1'b1);
        cyc(25);
        chk({31'h0, in_pos1}, 32'h0);
        host_u.step(2, 10);
        ip(1'b1, 1'b1);
        // a command inside the hold drops the output at once
        host_u.levels(1'b0, 1'b1, 1'b0);
        cyc(3);
        host_u.levels(1'b0, 1'b0, 1'b0);
        cyc(5);
        chk({31'h0, in_pos1}, 32'h1);
        host_u.levels(1'b0, 1'b1, 1'b0);
        cyc(2);
        chk({31'h0, in_pos1}, 32'h0);
        // hold 0 lasts until the next command, however long
        wr(dz_pkg::OFS_HOLD, 32'h0);
        host_u.levels(1'b0, 1'b0, 1'b0);
        host_u.step(0, 10);
        cyc(100);
        chk({31'h0, in_pos1}, 32'h1);
        rd(dz_pkg::OFS_STATUS, 32'h0000000F);
        host_u.levels(1'b0, 1'b1, 1'b0);
        cyc(2);
        chk({31'h0, in_pos1}, 32'h0);
        print_verdict();
    end
endmodule
